// >>> core/ufc_cfg.svh
// Offsets, field positions, reset values and levels of the flow block.
// Assumes inclusion by the design, checker and bench files; definitions, no logic.
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
// Register index within a channel window (byte address = 4 * index)
`define UFC_IDX_SCRATCH   4'h0
`define UFC_IDX_EFC       4'h1
`define UFC_IDX_IER       4'h2
`define UFC_IDX_ISR       4'h3
`define UFC_IDX_LCR       4'h4
`define UFC_IDX_MCR       4'h5
`define UFC_IDX_LSR       4'h6
`define UFC_IDX_MSR       4'h7
`define UFC_IDX_FCR       4'h8
`define UFC_IDX_RES1      4'h9
`define UFC_IDX_RES2      4'hA
`define UFC_IDX_PAU1      4'hB
`define UFC_IDX_PAU2      4'hC
`define UFC_IDX_EVSTAT    4'hD
`define UFC_IDX_EVCLR     4'hE
`define UFC_IDX_EVEN      4'hF
// Enhanced feature control fields
`define UFC_EFC_ACTS      7
`define UFC_EFC_ARTS      6
`define UFC_EFC_SPEC      5
`define UFC_EFC_ENH       4
// Modem control fields
`define UFC_MCR_DTR       0
`define UFC_MCR_RTS       1
`define UFC_MCR_OP1       2
`define UFC_MCR_OP2       3
`define UFC_MCR_LOOP      4
// Reset values
`define UFC_LSR_RST       8'h60
`define UFC_ZERO8         8'h00
// Receive trigger levels picked by fifo control bits 7:6
`define UFC_TRIG0         5'h01
`define UFC_TRIG1         5'h04
`define UFC_TRIG2         5'h08
`define UFC_TRIG3         5'h0E
// Event bit positions in the event status register
`define UFC_EV_SPEC       0
`define UFC_EV_TRIG       1
`define UFC_EV_MODEM      2
`define UFC_EV_PAUSE      3
`endif

// >>> core/ufc_pkg.sv
// Types shared by the flow-control block and its bench.
// Assumes the constants header is included where fields are used.
package ufc_pkg;
	// Active-low modem inputs of one channel
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} ufc_modem_in_type;
	// One received character
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ufc_rx_char_type;
	// Pin outputs of one channel
	typedef struct packed {
		logic txd;
		logic rts_n;
		logic dtr_n;
		logic receive_dma_ready_n;
		logic transmit_dma_ready_n;
	} ufc_pins_out_type;
	// Flow character sender state
	typedef enum logic [2:0] {
		UFC_FC_IDLE   = 3'b001,
		UFC_FC_FIRST  = 3'b010,
		UFC_FC_SECOND = 3'b100
	} ufc_fc_state_type;
endpackage

// >>> core/ufc_top.sv
// Flow control, scratch and reset state of a four-channel serial port.
// Assumes an APB master, and outside serialisers and fifos per channel.
// How it works
// - Scratch byte per channel reads back exactly what was written.
// - Auto clear-to-send: stop after current character while pin high.
// - Auto request-to-send: interrupt at trigger, throttle at next level.
// - Request-to-send released when fill drops below next lower level.
// - Without auto mode request-to-send follows modem control bit.
// - Special detect: match second pause char, keep it unless flow compare takes it as a pause code, flag status.
// - Character registers compare bit zero against first received bit.
// - Enhanced enable and status bits, and control bit 6, writable only when enabled.
// - Upper selection bits choose which flow pair is transmitted.
// - Lower selection bits choose which flow pair is compared.
// - Dual selection sends and matches the pair back to back.
// - Flow characters are codes only, except the first of a dual pair, which is passed on as data.
// - Reset zeroes control registers; interrupt status reads 01.
// - Line status reads 60 after reset.
// - Modem deltas clear at reset; upper bits follow pins.
// - Reset drives data, rts, dtr, rx ready high; tx ready low.
// - Clear-to-send status is inverted pin, or rts bit in loopback.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_top #(
	parameter int NCH = 4
) (
	// Clock, reset, enable
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          ce,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Modem pins and outside channel logic
	input  wire ufc_pkg::ufc_modem_in_type [NCH-1:0] modem_in,
	input  wire ufc_pkg::ufc_rx_char_type  [NCH-1:0] rx_char,
	input  wire logic [NCH-1:0][4:0]           rx_level,
	input  wire logic [NCH-1:0][7:0]           line_stat_in,
	input  wire logic [NCH-1:0]                tx_bit,
	input  wire logic [NCH-1:0]                tx_fifo_full,
	// Flow results
	output logic      [NCH-1:0]                rx_store,
	output logic      [NCH-1:0]                tx_allow,
	output logic      [NCH-1:0]                fc_valid,
	output logic      [NCH-1:0][7:0]           fc_char,
	input  wire logic [NCH-1:0]                fc_ready,
	// Pins and interrupt
	output ufc_pkg::ufc_pins_out_type [NCH-1:0] pins_out,
	output logic                               irq
);

	// Trigger level lookup, used for programmed, higher and lower levels
	function automatic logic [4:0] trig(input logic [1:0] s);
		case (s)
			2'h0: trig = `UFC_TRIG0;
			2'h1: trig = `UFC_TRIG1;
			2'h2: trig = `UFC_TRIG2;
			default: trig = `UFC_TRIG3;
		endcase
	endfunction

	logic [NCH-1:0][7:0] scr_r, efc_r, ier_r, lcr_r, mcr_r, fcr_r;
	logic [NCH-1:0][7:0] res1_r, res2_r, pau1_r, pau2_r, lsr_r;
	logic [NCH-1:0][1:0] isr_hi_r;
	logic [NCH-1:0][3:0] delta_r, prev_r, msr_hi, ev_r, ev_en_r;
	logic [NCH-1:0][3:0] ev_set;
	logic [NCH-1:0]      primed_r, full_r, at_trig_r, paused_r;
	logic [NCH-1:0]      half_res_r, half_pau_r, sent_pau_r;
	logic [NCH-1:0]      got_res, got_pau, got_spec, flow_hit;
	logic [NCH-1:0]      hi_hit, lo_hit, trig_hit;
	ufc_pkg::ufc_fc_state_type [NCH-1:0] fc_st_r;
	logic                wr, rd, bad;
	logic [1:0]          ch;
	logic [3:0]          idx;

	// Decode: channel in address bits 7:6, word index in 5:2
	assign bad = |paddr[11:8];
	assign ch  = paddr[7:6];
	assign idx = paddr[5:2];
	assign wr  = ce & psel & penable & pwrite & ~bad;
	assign rd  = ce & psel & penable & ~pwrite & ~bad;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & bad;

	// Modem status upper bits, loopback takes modem control bits
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			if (mcr_r[c][`UFC_MCR_LOOP]) begin
				msr_hi[c] = {mcr_r[c][`UFC_MCR_OP2],
					mcr_r[c][`UFC_MCR_OP1],
					mcr_r[c][`UFC_MCR_DTR],
					mcr_r[c][`UFC_MCR_RTS]};
			end else begin
				msr_hi[c] = ~modem_in[c];
			end
		end
	end

	// Plain control registers, written in full from the bus
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scr_r <= '0;
			efc_r <= '0;
			lcr_r <= '0;
			fcr_r <= '0;
			res1_r <= '0;
			res2_r <= '0;
			pau1_r <= '0;
			pau2_r <= '0;
		end else if (wr) begin
			case (idx)
				`UFC_IDX_SCRATCH: scr_r[ch] <= pwdata[7:0];
				`UFC_IDX_EFC:     efc_r[ch] <= pwdata[7:0];
				`UFC_IDX_LCR:     lcr_r[ch] <= pwdata[7:0];
				`UFC_IDX_FCR:     fcr_r[ch] <= pwdata[7:0];
				`UFC_IDX_RES1:    res1_r[ch] <= pwdata[7:0];
				`UFC_IDX_RES2:    res2_r[ch] <= pwdata[7:0];
				`UFC_IDX_PAU1:    pau1_r[ch] <= pwdata[7:0];
				`UFC_IDX_PAU2:    pau2_r[ch] <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Enhanced bits only move while the enhanced enable is set, so
	// older drivers cannot disturb them once the enable is cleared
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ier_r <= '0;
			mcr_r <= '0;
		end else if (wr) begin
			if (idx == `UFC_IDX_IER) begin
				ier_r[ch][3:0] <= pwdata[3:0];
				if (efc_r[ch][`UFC_EFC_ENH])
					ier_r[ch][7:4] <= pwdata[7:4];
			end
			if (idx == `UFC_IDX_MCR) begin
				mcr_r[ch][5:0] <= pwdata[5:0];
				mcr_r[ch][7] <= pwdata[7];
				if (efc_r[ch][`UFC_EFC_ENH])
					mcr_r[ch][6] <= pwdata[6];
			end
		end
	end

	// Status bits 5:4; a special match sets bit 4 over a clearing write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			isr_hi_r <= '0;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				if (wr && ch == 2'(c) && idx == `UFC_IDX_ISR &&
				    efc_r[c][`UFC_EFC_ENH])
					isr_hi_r[c] <= pwdata[5:4];
				if (got_spec[c])
					isr_hi_r[c][0] <= 1'b1;
			end
		end
	end

	// Line status copy, reads 60 until the line logic takes over
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			lsr_r <= {NCH{`UFC_LSR_RST}};
		else if (ce)
			lsr_r <= line_stat_in;
	end

	// Modem deltas; first cycle after reset only primes the history
	// so a pin already low does not fake a change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			delta_r  <= '0;
			prev_r   <= '0;
			primed_r <= '0;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				prev_r[c]   <= msr_hi[c];
				primed_r[c] <= 1'b1;
				if (rd && ch == 2'(c) && idx == `UFC_IDX_MSR)
					delta_r[c] <= '0;
				if (primed_r[c]) begin
					if (prev_r[c][0] != msr_hi[c][0])
						delta_r[c][0] <= 1'b1;
					if (prev_r[c][1] != msr_hi[c][1])
						delta_r[c][1] <= 1'b1;
					if (prev_r[c][2] & ~msr_hi[c][2])
						delta_r[c][2] <= 1'b1;
					if (prev_r[c][3] != msr_hi[c][3])
						delta_r[c][3] <= 1'b1;
				end
			end
		end
	end

	// Receive compare against the flow characters
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			logic [7:0] d;
			logic       v;
			d = rx_char[c].data;
			v = rx_char[c].valid;
			got_res[c] = 1'b0;
			got_pau[c] = 1'b0;
			case (efc_r[c][1:0])
				2'b10: begin
					got_res[c] = v & (d == res1_r[c]);
					got_pau[c] = v & (d == pau1_r[c]);
				end
				2'b01: begin
					got_res[c] = v & (d == res2_r[c]);
					got_pau[c] = v & (d == pau2_r[c]);
				end
				2'b11: begin
					got_res[c] = v & half_res_r[c] &
						(d == res2_r[c]);
					got_pau[c] = v & half_pau_r[c] &
						(d == pau2_r[c]);
				end
				default: ;
			endcase
			got_spec[c] = v & efc_r[c][`UFC_EFC_SPEC] &
				(d == pau2_r[c]);
			flow_hit[c] = got_res[c] | got_pau[c];
			rx_store[c] = v & ~flow_hit[c];
		end
	end

	// Pair tracking and pause state; the pair must be consecutive
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			half_res_r <= '0;
			half_pau_r <= '0;
			paused_r   <= '0;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				if (rx_char[c].valid) begin
					half_res_r[c] <= rx_char[c].data == res1_r[c];
					half_pau_r[c] <= rx_char[c].data == pau1_r[c];
				end
				if (efc_r[c][1:0] == 2'b00)
					paused_r[c] <= 1'b0;
				else if (got_pau[c])
					paused_r[c] <= 1'b1;
				else if (got_res[c])
					paused_r[c] <= 1'b0;
			end
		end
	end

	// Fill thresholds with hysteresis one trigger step each way
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			logic [1:0] s;
			s = fcr_r[c][7:6];
			hi_hit[c] = rx_level[c] >= trig((s == 2'h3) ? s : s + 2'h1);
			lo_hit[c] = rx_level[c] < trig((s == 2'h0) ? s : s - 2'h1);
			trig_hit[c] = rx_level[c] >= trig(s);
		end
	end

	// Throttle state shared by hardware and software flow control
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			full_r    <= '0;
			at_trig_r <= '0;
		end else if (ce) begin
			at_trig_r <= trig_hit;
			for (int c = 0; c < NCH; c++) begin
				if (hi_hit[c])
					full_r[c] <= 1'b1;
				else if (lo_hit[c])
					full_r[c] <= 1'b0;
			end
		end
	end

	// Flow character sender: one char, or the pair back to back
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fc_st_r    <= {NCH{ufc_pkg::UFC_FC_IDLE}};
			fc_valid   <= '0;
			fc_char    <= '0;
			sent_pau_r <= '0;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				case (fc_st_r[c])
					ufc_pkg::UFC_FC_IDLE: begin
						if (efc_r[c][3:2] != 2'b00 &&
						    full_r[c] != sent_pau_r[c]) begin
							sent_pau_r[c] <= full_r[c];
							fc_valid[c]   <= 1'b1;
							fc_st_r[c]    <= ufc_pkg::UFC_FC_FIRST;
							if (efc_r[c][3])
								fc_char[c] <= full_r[c] ?
									pau1_r[c] : res1_r[c];
							else
								fc_char[c] <= full_r[c] ?
									pau2_r[c] : res2_r[c];
						end
					end
					ufc_pkg::UFC_FC_FIRST: begin
						if (fc_ready[c]) begin
							if (efc_r[c][3:2] == 2'b11) begin
								fc_char[c] <= sent_pau_r[c] ?
									pau2_r[c] : res2_r[c];
								fc_st_r[c] <= ufc_pkg::UFC_FC_SECOND;
							end else begin
								fc_valid[c] <= 1'b0;
								fc_st_r[c]  <= ufc_pkg::UFC_FC_IDLE;
							end
						end
					end
					ufc_pkg::UFC_FC_SECOND: begin
						if (fc_ready[c]) begin
							fc_valid[c] <= 1'b0;
							fc_st_r[c]  <= ufc_pkg::UFC_FC_IDLE;
						end
					end
					default: begin
						fc_valid[c] <= 1'b0;
						fc_st_r[c]  <= ufc_pkg::UFC_FC_IDLE;
					end
				endcase
			end
		end
	end

	// Transmit gate; the serialiser checks it between characters only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_allow <= '1;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++)
				tx_allow[c] <= ~(efc_r[c][`UFC_EFC_ACTS] &
					modem_in[c].cts_n) & ~paused_r[c];
		end
	end

	// Pins, all held at their idle levels from reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < NCH; c++)
				pins_out[c] <= 5'b11110;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				pins_out[c].txd <= tx_bit[c];
				pins_out[c].dtr_n <= ~mcr_r[c][`UFC_MCR_DTR];
				if (efc_r[c][`UFC_EFC_ARTS])
					pins_out[c].rts_n <= full_r[c] |
						~mcr_r[c][`UFC_MCR_RTS];
				else
					pins_out[c].rts_n <=
						~mcr_r[c][`UFC_MCR_RTS];
				pins_out[c].receive_dma_ready_n <= rx_level[c] == 5'h00;
				pins_out[c].transmit_dma_ready_n <= tx_fifo_full[c];
			end
		end
	end

	// Event sources for the sticky status
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			ev_set[c] = '0;
			ev_set[c][`UFC_EV_SPEC]  = got_spec[c];
			ev_set[c][`UFC_EV_TRIG]  = efc_r[c][`UFC_EFC_ARTS] &
				trig_hit[c] & ~at_trig_r[c];
			ev_set[c][`UFC_EV_MODEM] = primed_r[c] &
				(prev_r[c] != msr_hi[c]);
			ev_set[c][`UFC_EV_PAUSE] = got_pau[c];
		end
	end

	// Sticky status, write-one clear; a new event beats the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ev_r    <= '0;
			ev_en_r <= '0;
		end else if (ce) begin
			for (int c = 0; c < NCH; c++) begin
				if (wr && ch == 2'(c) && idx == `UFC_IDX_EVEN)
					ev_en_r[c] <= pwdata[3:0];
				if (wr && ch == 2'(c) && idx == `UFC_IDX_EVCLR)
					ev_r[c] <= (ev_r[c] & ~pwdata[3:0]) | ev_set[c];
				else
					ev_r[c] <= ev_r[c] | ev_set[c];
			end
		end
	end

	assign irq = |(ev_r & ev_en_r);

	// Read mux, zero wait; unused bits read zero
	always_comb begin
		prdata = '0;
		if (!bad) begin
			case (idx)
				`UFC_IDX_SCRATCH: prdata[7:0] = scr_r[ch];
				`UFC_IDX_EFC:     prdata[7:0] = efc_r[ch];
				`UFC_IDX_IER:     prdata[7:0] = ier_r[ch];
				`UFC_IDX_ISR:     prdata[7:0] = {2'b00, isr_hi_r[ch],
					3'b000, ~|(ev_r[ch] & ev_en_r[ch])};
				`UFC_IDX_LCR:     prdata[7:0] = lcr_r[ch];
				`UFC_IDX_MCR:     prdata[7:0] = mcr_r[ch];
				`UFC_IDX_LSR:     prdata[7:0] = lsr_r[ch];
				`UFC_IDX_MSR:     prdata[7:0] = {msr_hi[ch],
					delta_r[ch]};
				`UFC_IDX_FCR:     prdata[7:0] = fcr_r[ch];
				`UFC_IDX_RES1:    prdata[7:0] = res1_r[ch];
				`UFC_IDX_RES2:    prdata[7:0] = res2_r[ch];
				`UFC_IDX_PAU1:    prdata[7:0] = pau1_r[ch];
				`UFC_IDX_PAU2:    prdata[7:0] = pau2_r[ch];
				`UFC_IDX_EVSTAT:  prdata[3:0] = ev_r[ch];
				`UFC_IDX_EVEN:    prdata[3:0] = ev_en_r[ch];
				default:          prdata = '0;
			endcase
		end
	end

endmodule

// >>> tb/ufc_checker.sv
// Checker of the flow block, bound to its top; watches channel 0.
// Assumes channel 0 settings change only through APB writes.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_checker #(
	parameter int NCH = 4
) (
	// Clock, reset, enable
	input wire logic                                clk,
	input wire logic                                resetn,
	input wire logic                                ce,
	// APB
	input wire logic                                psel,
	input wire logic                                penable,
	input wire logic                                pwrite,
	input wire logic [11:0]                         paddr,
	input wire logic [31:0]                         pwdata,
	input wire logic [31:0]                         prdata,
	input wire logic                                pready,
	// Line side and pins
	input wire ufc_pkg::ufc_modem_in_type [NCH-1:0] modem_in,
	input wire ufc_pkg::ufc_rx_char_type [NCH-1:0]  rx_char,
	input wire logic [NCH-1:0][4:0]                 rx_level,
	input wire logic [NCH-1:0]                      rx_store,
	input wire logic [NCH-1:0]                      tx_allow,
	input wire logic [NCH-1:0]                      fc_valid,
	input wire logic [NCH-1:0][7:0]                 fc_char,
	input wire logic [NCH-1:0]                      fc_ready,
	input wire ufc_pkg::ufc_pins_out_type [NCH-1:0] pins_out,
	input wire logic                                irq
);
	logic [7:0] efc_r;
	logic [7:0] mcr_r;
	logic [7:0] fcr_r;
	logic [1:0] quiet_r;
	logic [4:0] hi;
	logic [4:0] lo;
	logic       wr;
	// Shadow settings; quiet_r lets the design settle after any write
	assign wr = psel && penable && pwrite && ce && pready;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			efc_r <= 8'h00;
			mcr_r <= 8'h00;
			fcr_r <= 8'h00;
			quiet_r <= 2'h0;
		end else begin
			quiet_r <= wr ? 2'h0 : quiet_r + {1'b0, quiet_r != 2'h3};
			if (wr && paddr == {6'h00, `UFC_IDX_EFC, 2'h0})
				efc_r <= pwdata[7:0];
			if (wr && paddr == {6'h00, `UFC_IDX_MCR, 2'h0})
				mcr_r <= pwdata[7:0];
			if (wr && paddr == {6'h00, `UFC_IDX_FCR, 2'h0})
				fcr_r <= pwdata[7:0];
		end
	end
	// Throttle level is the next trigger up, release the next one down
	assign hi = fcr_r[7:6] == 2'h0 ? `UFC_TRIG1 :
		fcr_r[7:6] == 2'h1 ? `UFC_TRIG2 : `UFC_TRIG3;
	assign lo = fcr_r[7] ? (fcr_r[6] ? `UFC_TRIG2 : `UFC_TRIG1) : `UFC_TRIG0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reset_pins: assert property (disable iff (1'b0)
		!resetn |-> pins_out[0] == 5'h1E && !irq && tx_allow == '1)
		else $error("pins wrong in reset");
	a_read_upper: assert property (
		psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_store_valid: assert property (
		rx_store[0] |-> rx_char[0].valid)
		else $error("store without character");
	a_fc_hold: assert property (
		fc_valid[0] && !fc_ready[0] |=> fc_valid[0] && $stable(fc_char[0]))
		else $error("flow character dropped");
	a_cts_follow: assert property (
		(quiet_r == 2'h3 && efc_r[7] && efc_r[1:0] == 2'h0 &&
		$stable(modem_in[0].cts_n)) [*4] |->
		tx_allow[0] == !modem_in[0].cts_n)
		else $error("transmit gate ignores cts");
	a_rts_manual: assert property (
		quiet_r == 2'h3 && !efc_r[6] && !mcr_r[4] |->
		pins_out[0].rts_n == !mcr_r[1] && pins_out[0].dtr_n == !mcr_r[0])
		else $error("modem pins differ from control");
	a_rts_throttle: assert property (
		quiet_r == 2'h3 && efc_r[6] && rx_level[0] >= hi |->
		##[1:3] pins_out[0].rts_n)
		else $error("rts not raised at level");
	a_rts_release: assert property (
		quiet_r == 2'h3 && efc_r[6] && mcr_r[1] && !mcr_r[4] &&
		rx_level[0] < lo |-> ##[1:3] !pins_out[0].rts_n)
		else $error("rts not released");
endmodule
bind ufc_top ufc_checker #(.NCH(NCH)) chk (.clk, .resetn, .ce, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .modem_in,
	.rx_char, .rx_level, .rx_store, .tx_allow, .fc_valid, .fc_char,
	.fc_ready, .pins_out, .irq);

// >>> tb/ufc_peer.sv
// Modem and remote peer model; channel 0 is active, others idle.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module ufc_peer (
	// Clock
	input wire logic                           clk,
	// Toward the design
	output ufc_pkg::ufc_modem_in_type [3:0]    modem_in,
	output ufc_pkg::ufc_rx_char_type [3:0]     rx_char,
	output logic [3:0][4:0]                    rx_level,
	output logic [3:0][7:0]                    line_stat_in,
	output logic [3:0]                         tx_bit,
	output logic [3:0]                         tx_fifo_full,
	output logic [3:0]                         fc_ready,
	// From the design
	input wire logic [3:0]                     rx_store,
	input wire logic [3:0]                     fc_valid,
	input wire logic [3:0][7:0]                fc_char
);
	logic       slow = 1'b0;
	logic [7:0] got[$];
	// Carrier present, other modem lines inactive
	initial begin
		modem_in = {4{4'b0111}};
		rx_char = '0;
		rx_level = '0;
		line_stat_in = {4{8'h61}};
		tx_bit = '0;
		tx_fifo_full = '0;
		fc_ready = '1;
	end
	// Toggling lines keep pass-through paths busy; slow halves acceptance
	always @(posedge clk) begin
		tx_bit <= ~tx_bit;
		// Idle channels toggle the top bit of their modem, level and line status inputs; the other bits stay constant
		modem_in[3:1] <= {3{tx_bit[0], 3'b111}};
		rx_level[3:1] <= {3{tx_bit[0], 4'h3}};
		line_stat_in[3:1] <= {3{tx_bit[0], 7'h60}};
		tx_fifo_full <= tx_bit;
		fc_ready <= slow ? ~fc_ready : 4'hF;
		if (fc_valid[0] && fc_ready[0])
			got.push_back(fc_char[0]);
	end
	// One received character, flow codes sent only as codes
	task automatic send(input logic [7:0] b, output logic s);
		@(posedge clk);
		rx_char[0] <= {1'b1, b};
		#1 s = rx_store[0];
		@(posedge clk);
		rx_char[0].valid <= 1'b0;
	endtask
	task automatic lvl(input logic [4:0] l);
		@(posedge clk);
		rx_level[0] <= l;
	endtask
	task automatic cts(input logic v);
		@(posedge clk);
		modem_in[0].cts_n <= v;
	endtask
endmodule

// >>> tb/ufc_top_tb.sv
// Bench: register and flow scenarios on channel 0 through APB.
// Assumes the peer model on the line side and the bound checker.
`timescale 1ns/10ps
`include "ufc_cfg.svh"
module ufc_top_tb;
	logic                             clk = 1'b0;
	logic                             resetn = 1'b1;
	logic                             ce = 1'b0;
	logic                             psel = 1'b0;
	logic                             penable = 1'b0;
	logic                             pwrite = 1'b0;
	logic [11:0]                      paddr = 12'h000;
	logic [31:0]                      pwdata = 32'h0;
	logic [31:0]                      prdata;
	logic [31:0]                      r;
	logic                             pready;
	logic                             pslverr;
	logic                             slv;
	logic                             irq;
	ufc_pkg::ufc_modem_in_type [3:0]  modem_in;
	ufc_pkg::ufc_rx_char_type [3:0]   rx_char;
	ufc_pkg::ufc_pins_out_type [3:0]  pins_out;
	logic [3:0][4:0]                  rx_level;
	logic [3:0][7:0]                  line_stat_in;
	logic [3:0][7:0]                  fc_char;
	logic [3:0]                       tx_bit;
	logic [3:0]                       tx_fifo_full;
	logic [3:0]                       rx_store;
	logic [3:0]                       tx_allow;
	logic [3:0]                       fc_valid;
	logic [3:0]                       fc_ready;
	logic [7:0]                       exq[$];
	logic [3:0]                       ri[8] = '{1, 2, 3, 4, 5, 6, 7, 8};
	logic [7:0]                       rv[8] = '{0, 0, 1, 0, 0, 8'h60, 8'h80, 0};
	int                               errors = 0;
	int                               num_checks = 0;
	int                               cycles = 0;
	always #12.5 clk = ~clk;
	ufc_top dut (.clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .modem_in, .rx_char,
		.rx_level, .line_stat_in, .tx_bit, .tx_fifo_full, .rx_store,
		.tx_allow, .fc_valid, .fc_char, .fc_ready, .pins_out, .irq);
	ufc_peer peer (.clk, .modem_in, .rx_char, .rx_level, .line_stat_in,
		.tx_bit, .tx_fifo_full, .fc_ready, .rx_store, .fc_valid, .fc_char);
	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// Setup then access phase; data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [1:0] c, input logic [3:0] i,
		input logic [7:0] d);
		apb(1'b1, {4'h0, c, i, 2'h0}, d);
	endtask
	task automatic rd(input logic [1:0] c, input logic [3:0] i,
		input logic [7:0] e, input string n);
		apb(1'b0, {4'h0, c, i, 2'h0}, 8'h00);
		chk(n, {24'h0, e}, r);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rxc(input logic [7:0] b, input logic e);
		logic s;
		peer.send(b, s);
		chk("stored", e, s);
	endtask
	task automatic end_of_test();
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// Main sequence; the reset value reads run with ce low so nothing updates
	initial begin
		// Falling edge at time zero, so reset acts before the first clock
		resetn <= 1'b0;
		repeat (10) @(posedge clk);
		chk("reset pins", 32'h1E, 32'(pins_out[0]));
		resetn <= 1'b1;
		for (int k = 0; k < 8; k++)
			rd(0, ri[k], rv[k], "reset");
		ce <= 1'b1;
		wr(0, `UFC_IDX_SCRATCH, 8'hA5);
		wr(3, `UFC_IDX_SCRATCH, 8'h5A);
		rd(0, `UFC_IDX_SCRATCH, 8'hA5, "scratch 0");
		rd(3, `UFC_IDX_SCRATCH, 8'h5A, "scratch 3");
		apb(1'b0, 12'h100, 8'h00);
		chk("unmapped", 32'h1, {31'h0, slv});
		wr(0, `UFC_IDX_LSR, 8'h00);
		rd(0, `UFC_IDX_LSR, 8'h61, "line status");
		wr(0, `UFC_IDX_IER, 8'hF3);
		rd(0, `UFC_IDX_IER, 8'h03, "ier locked");
		wr(0, `UFC_IDX_EFC, 8'h10);
		wr(0, `UFC_IDX_IER, 8'hF3);
		rd(0, `UFC_IDX_IER, 8'hF3, "ier open");
		wr(0, `UFC_IDX_EFC, 8'h00);
		wr(0, `UFC_IDX_IER, 8'h00);
		rd(0, `UFC_IDX_IER, 8'hF0, "ier latched");
		wr(0, `UFC_IDX_FCR, 8'h41);
		wr(0, `UFC_IDX_MCR, 8'h02);
		wr(0, `UFC_IDX_EFC, 8'h40);
		wr(0, `UFC_IDX_EVEN, 8'h02);
		peer.lvl(5'h04);
		wt(4);
		chk("trigger irq", 1, irq);
		chk("rts at trigger", 0, pins_out[0].rts_n);
		peer.lvl(5'h08);
		wt(4);
		chk("rts throttle", 1, pins_out[0].rts_n);
		wr(0, `UFC_IDX_EVEN, 8'h00);
		wt(1);
		chk("irq masked", 0, irq);
		rd(0, `UFC_IDX_EVSTAT, 8'h02, "events");
		peer.lvl(5'h00);
		wt(4);
		chk("rts release", 0, pins_out[0].rts_n);
		wr(0, `UFC_IDX_EVCLR, 8'h02);
		wr(0, `UFC_IDX_EVEN, 8'h02);
		wt(1);
		chk("irq cleared", 0, irq);
		wr(0, `UFC_IDX_PAU2, 8'h13);
		wr(0, `UFC_IDX_EFC, 8'h20);
		wr(0, `UFC_IDX_EVEN, 8'h01);
		rxc(8'hC8, 1'b1);
		wt(2);
		chk("no special", 0, irq);
		rxc(8'h13, 1'b1);
		wt(2);
		chk("special", 1, irq);
		rd(0, `UFC_IDX_ISR, 8'h10, "isr special");
		wr(0, `UFC_IDX_RES1, 8'hC1);
		wr(0, `UFC_IDX_RES2, 8'hC2);
		wr(0, `UFC_IDX_PAU1, 8'hB1);
		wr(0, `UFC_IDX_PAU2, 8'hB2);
		peer.slow = 1'b1;
		for (int m = 1; m < 4; m++) begin
			wr(0, `UFC_IDX_EFC, 8'h40 | 8'(m << 2));
			peer.got.delete();
			peer.lvl(5'h08);
			wt(12);
			peer.lvl(5'h00);
			wt(12);
			exq = {};
			if (m != 1) exq.push_back(8'hB1);
			if (m != 2) exq.push_back(8'hB2);
			if (m != 1) exq.push_back(8'hC1);
			if (m != 2) exq.push_back(8'hC2);
			chk("flow count", exq.size(), peer.got.size());
			foreach (exq[k])
				chk("flow char", exq[k], peer.got[k]);
		end
		for (int m = 1; m < 3; m++) begin
			wr(0, `UFC_IDX_EFC, 8'(m));
			rxc(m == 2 ? 8'hB1 : 8'hB2, 1'b0);
			wt(3);
			chk("paused", 0, tx_allow[0]);
			rxc(m == 2 ? 8'hC1 : 8'hC2, 1'b0);
			wt(3);
			chk("resumed", 1, tx_allow[0]);
		end
		wr(0, `UFC_IDX_EFC, 8'h03);
		rxc(8'hB2, 1'b1);
		wt(3);
		chk("lone second", 1, tx_allow[0]);
		rxc(8'hB1, 1'b1);
		rxc(8'hB2, 1'b0);
		wt(3);
		chk("pair pause", 0, tx_allow[0]);
		rxc(8'hC1, 1'b1);
		rxc(8'hC2, 1'b0);
		wt(3);
		chk("pair resume", 1, tx_allow[0]);
		wr(0, `UFC_IDX_EFC, 8'h80);
		peer.cts(1'b0);
		wt(6);
		chk("cts go", 1, tx_allow[0]);
		peer.cts(1'b1);
		wt(6);
		chk("cts stop", 0, tx_allow[0]);
		rd(0, `UFC_IDX_MSR, 8'h81, "msr cts");
		wr(0, `UFC_IDX_MCR, 8'h12);
		rd(0, `UFC_IDX_MSR, 8'h19, "msr loop");
		end_of_test();
	end
endmodule
